/* design/servo_step_quadrature_io.sv */
`default_nettype none
module servo_step_quadrature_io #(
	parameter int FB_BITS  = 20,
	parameter int GEAR_W   = 16,
	parameter int FILT_LEN = servo_io_pkg::FILTER_CYCLES
) (
	input  wire logic               core_clk,
	input  wire logic               reset,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [11:0]        paddr,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	input  wire logic               drivePowered,
	input  wire logic               driveFaulted,
	input  wire logic               driveEnabled,
	input  wire logic               hiResFeedback,
	input  wire logic               serialFeedback,
	input  wire logic [FB_BITS-1:0] feedbackPos,
	input  wire logic [3:0]         resolutionRotarySwitch,
	input  wire logic               highSpeedStepInput,
	input  wire logic               directionInput,
	input  wire logic               quadChanAIn,
	input  wire logic               quadChanBIn,
	output logic                    quadChanAOut,
	output logic                    quadChanAOe,
	output logic                    quadChanBOut,
	output logic                    quadChanBOe,
	output logic                    markerPulseOutput,
	output logic                    faultStatusOutput,
	output logic                    runStatusOutput,
	output logic      [31:0]        positionCommand
);
	// ==================================================================
	// resolution tables
	function automatic logic [15:0] userPprOf(input logic [3:0] sel);
		case (sel)
			4'h0: userPprOf = 16'd128;
			4'h1: userPprOf = 16'd512;
			4'h2: userPprOf = 16'd1024;
			4'h3: userPprOf = 16'd2048;
			4'h4: userPprOf = 16'd4096;
			4'h5: userPprOf = 16'd8192;
			4'h6: userPprOf = 16'd16384;
			4'h7: userPprOf = 16'd32768;
			4'h8: userPprOf = 16'd125;
			4'h9: userPprOf = 16'd500;
			4'ha: userPprOf = 16'd1000;
			4'hb: userPprOf = 16'd2000;
			4'hc: userPprOf = 16'd2500;
			4'hd: userPprOf = 16'd5000;
			4'he: userPprOf = 16'd10000;
			default: userPprOf = 16'd20000;
		endcase
	endfunction

	function automatic logic [15:0] switchPprOf(input logic [3:0] pos,
			input logic [15:0] userPpr);
		case (pos)
			4'h1: switchPprOf = 16'd512;
			4'h2: switchPprOf = 16'd1000;
			4'h3: switchPprOf = 16'd1024;
			4'h4: switchPprOf = 16'd2000;
			4'h5: switchPprOf = 16'd2048;
			4'h6: switchPprOf = 16'd4096;
			4'h7: switchPprOf = 16'd5000;
			4'h8: switchPprOf = 16'd8192;
			4'h9: switchPprOf = 16'd10000;
			default: switchPprOf = userPpr; // position 0 (and unused)
		endcase
	endfunction

	// phase 0..3 of a quadrature pair; increasing phase means A leads B
	function automatic logic [1:0] phaseOf(input logic a, input logic b);
		phaseOf = {b, a ^ b};
	endfunction

	localparam int NIN = 4; // step, direction, channel A, channel B
	localparam logic [1:0] PH_FWD = 2'h1;
	localparam logic [1:0] PH_BWD = 2'h3;

	// ==================================================================
	// registers
	localparam int PPR_W_L = servo_io_pkg::PPR_W;
	logic [3:0]        ctrl_q;
	logic [GEAR_W-1:0] gearNum_q;
	logic [GEAR_W-1:0] gearDen_q;
	logic [3:0]        userPprSel_q;
	logic [31:0]       stepCount_q;
	logic signed [31:0] quadCount_q;
	logic [31:0]       posCmd_q;
	logic [3:0]        rotSync1_q;
	logic [3:0]        rotSync2_q;
	logic [NIN-1:0]    sync1_q;
	logic [NIN-1:0]    sync2_q;
	logic [NIN-1:0]    filt_q;
	logic [NIN-1:0]    filtPrev_q;
	logic [3:0]        filtCnt_q [NIN];
	logic [PPR_W_L-1:0] emuCount_q;
	logic [7:0]        gapCnt_q;

	logic posMode;
	logic quadSrc;
	logic aIsInput;
	logic bIsInput;
	assign posMode  = ctrl_q[servo_io_pkg::CTRL_POS_MODE];
	assign quadSrc  = ctrl_q[servo_io_pkg::CTRL_QUAD_SRC];
	assign aIsInput = ctrl_q[servo_io_pkg::CTRL_A_INPUT] | quadSrc;
	assign bIsInput = ctrl_q[servo_io_pkg::CTRL_B_INPUT] | quadSrc;

	// ==================================================================
	// apb slave: one setup, one access cycle, no wait states
	logic setupPhase;
	logic accessWr;
	assign setupPhase = psel & ~penable;
	assign accessWr   = psel & penable & pready & pwrite;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= setupPhase;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
			if (setupPhase) begin
				case (paddr)
					servo_io_pkg::OFS_CTRL:       prdata <= {28'h0, ctrl_q};
					servo_io_pkg::OFS_GEAR_NUM:   prdata <= 32'(gearNum_q);
					servo_io_pkg::OFS_GEAR_DEN:   prdata <= 32'(gearDen_q);
					servo_io_pkg::OFS_USER_PPR:
						prdata <= {28'h0, userPprSel_q};
					servo_io_pkg::OFS_STATUS:
						prdata <= {20'h0, rotSync2_q, filt_q,
							faultStatusOutput, runStatusOutput,
							aIsInput, bIsInput};
					servo_io_pkg::OFS_POS_CMD:    prdata <= posCmd_q;
					servo_io_pkg::OFS_STEP_COUNT: prdata <= stepCount_q;
					servo_io_pkg::OFS_QUAD_COUNT: prdata <= quadCount_q;
					default:                      pslverr <= 1'b1;
				endcase
			end
		end
	end

	// writable control; both channels leave reset as outputs
	always_ff @(posedge core_clk) begin
		if (reset) begin
			ctrl_q       <= servo_io_pkg::CTRL_RESET;
			gearNum_q    <= servo_io_pkg::GEAR_RESET[GEAR_W-1:0];
			gearDen_q    <= servo_io_pkg::GEAR_RESET[GEAR_W-1:0];
			userPprSel_q <= servo_io_pkg::USER_PPR_RESET;
		end else if (accessWr) begin
			case (paddr)
				servo_io_pkg::OFS_CTRL:     ctrl_q <= pwdata[3:0];
				servo_io_pkg::OFS_GEAR_NUM: gearNum_q <= pwdata[GEAR_W-1:0];
				servo_io_pkg::OFS_GEAR_DEN: gearDen_q <= pwdata[GEAR_W-1:0];
				servo_io_pkg::OFS_USER_PPR: userPprSel_q <= pwdata[3:0];
				default: ;
			endcase
		end
	end

	// ==================================================================
	// status outputs, straight from drive state
	always_ff @(posedge core_clk) begin
		if (reset) begin
			faultStatusOutput <= 1'b0;
			runStatusOutput   <= 1'b0;
		end else begin
			faultStatusOutput <= drivePowered & ~driveFaulted;
			runStatusOutput   <= drivePowered & ~driveFaulted
				& driveEnabled;
		end
	end

	// ==================================================================
	// pin synchronisers and glitch filters
	// a level is accepted only after it has held FILT_LEN cycles, so
	// contact bounce or line ringing shorter than that never yields a double count
	logic [NIN-1:0] pinsRaw;
	assign pinsRaw = {quadChanBIn, quadChanAIn, directionInput,
		highSpeedStepInput};

	always_ff @(posedge core_clk) begin
		if (reset) begin
			sync1_q    <= '0;
			sync2_q    <= '0;
			filt_q     <= '0;
			filtPrev_q <= '0;
			rotSync1_q <= 4'h0;
			rotSync2_q <= 4'h0;
			for (int i = 0; i < NIN; i++) filtCnt_q[i] <= 4'h0;
		end else begin
			sync1_q    <= pinsRaw;
			sync2_q    <= sync1_q;
			rotSync1_q <= resolutionRotarySwitch;
			rotSync2_q <= rotSync1_q;
			filtPrev_q <= filt_q;
			for (int i = 0; i < NIN; i++) begin
				if (sync2_q[i] == filt_q[i]) begin
					filtCnt_q[i] <= 4'h0;
				end else if (filtCnt_q[i] == 4'(FILT_LEN - 1)) begin
					filt_q[i]    <= sync2_q[i];
					filtCnt_q[i] <= 4'h0;
				end else begin
					filtCnt_q[i] <= filtCnt_q[i] + 4'h1;
				end
			end
		end
	end

	// ==================================================================
	// step / direction command
	logic stepMode;
	logic stepFall;
	logic stepRise;
	logic quadMode;
	assign stepMode = posMode & ~quadSrc;
	assign quadMode = posMode & quadSrc;
	assign stepFall = filtPrev_q[0] & ~filt_q[0]; // current stops
	assign stepRise = ~filtPrev_q[0] & filt_q[0];

	always_ff @(posedge core_clk) begin
		if (reset) begin
			stepCount_q <= 32'h0000_0000;
		end else if (stepMode && stepFall) begin
			stepCount_q <= stepCount_q + 32'h1;
		end
	end

	// ==================================================================
	// quadrature decode, 4x
	logic [1:0] phNow;
	logic [1:0] phDelta;
	assign phNow   = phaseOf(filt_q[2], filt_q[3]);
	assign phDelta = phNow - phaseOf(filtPrev_q[2], filtPrev_q[3]);

	// a skipped phase (delta 2) is dropped: direction is unknowable
	always_ff @(posedge core_clk) begin
		if (reset) begin
			quadCount_q <= 32'sh0;
		end else if (quadMode && aIsInput && bIsInput) begin
			if (phDelta == PH_FWD) quadCount_q <= quadCount_q + 32'sh1;
			else if (phDelta == PH_BWD)
				quadCount_q <= quadCount_q - 32'sh1;
		end
	end

	// gear scaling; a zero denominator freezes the command
	logic signed [GEAR_W+32:0] gearProd;
	assign gearProd = quadCount_q * $signed({1'b0, gearNum_q});

	always_ff @(posedge core_clk) begin
		if (reset) begin
			posCmd_q <= 32'h0000_0000;
		end else if (stepMode && stepFall) begin
			if (!filt_q[1]) posCmd_q <= posCmd_q + 32'h1;
			else posCmd_q <= posCmd_q - 32'h1;
		end else if (quadMode && gearDen_q != '0) begin
			posCmd_q <= 32'(gearProd
				/ $signed({1'b0, gearDen_q}));
		end
	end
	assign positionCommand = posCmd_q;

	// ==================================================================
	// encoder emulation
	logic [15:0]         pprSel;
	logic [PPR_W_L-1:0]  pprX4;
	logic [PPR_W_L-1:0]  target;
	logic [PPR_W_L:0]    diff;
	logic [FB_BITS+PPR_W_L-1:0] scaled;
	logic                emuStep;
	assign pprSel = switchPprOf(rotSync2_q, userPprOf(userPprSel_q));
	assign pprX4  = PPR_W_L'({pprSel, 2'b00});
	assign scaled = feedbackPos * pprX4;
	assign target = scaled[FB_BITS +: PPR_W_L];
	assign diff   = (target >= emuCount_q)
		? {1'b0, target - emuCount_q}
		: {1'b0, target - emuCount_q + pprX4};
	// one count per gap keeps count rate at or below 5 MHz
	assign emuStep = hiResFeedback && diff != '0
		&& gapCnt_q == 8'h0;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			gapCnt_q <= 8'h0;
		end else if (emuStep) begin
			gapCnt_q <= 8'(servo_io_pkg::QUAD_GAP_CYCLES - 1);
		end else if (gapCnt_q != 8'h0) begin
			gapCnt_q <= gapCnt_q - 8'h1;
		end
	end

	// follows the feedback by the short way round the revolution
	always_ff @(posedge core_clk) begin
		if (reset || !hiResFeedback) begin
			emuCount_q <= '0;
		end else if (emuCount_q >= pprX4) begin
			emuCount_q <= '0; // resolution shrank under the counter
		end else if (emuStep) begin
			if (diff <= {1'b0, pprX4 >> 1}) begin
				emuCount_q <= (emuCount_q == pprX4 - 1'b1)
					? '0 : emuCount_q + 1'b1;
			end else begin
				emuCount_q <= (emuCount_q == '0)
					? pprX4 - 1'b1 : emuCount_q - 1'b1;
			end
		end
	end

	// channel pins; quiet low without high-resolution feedback
	always_ff @(posedge core_clk) begin
		if (reset) begin
			quadChanAOut      <= 1'b0;
			quadChanBOut      <= 1'b0;
			quadChanAOe       <= 1'b1;
			quadChanBOe       <= 1'b1;
			markerPulseOutput <= 1'b0;
		end else begin
			quadChanAOe  <= ~aIsInput;
			quadChanBOe  <= ~bIsInput;
			quadChanAOut <= hiResFeedback
				& (emuCount_q[1] ^ emuCount_q[0]);
			quadChanBOut <= hiResFeedback & emuCount_q[1];
			markerPulseOutput <= serialFeedback && hiResFeedback
				&& emuCount_q < PPR_W_L'(2);
		end
	end

	// ==================================================================
	// checks
	property p_fault;
		@(posedge core_clk) disable iff (reset)
		##1 faultStatusOutput == $past(drivePowered & ~driveFaulted);
	endproperty
	a_fault: assert property (p_fault)
		else $error("fault output does not track power and fault");

	property p_run;
		@(posedge core_clk) disable iff (reset)
		(driveFaulted || !driveEnabled) |=> !runStatusOutput;
	endproperty
	a_run: assert property (p_run)
		else $error("run output on while faulted or disabled");

	property p_step_up;
		@(posedge core_clk) disable iff (reset)
		stepMode && stepFall && !filt_q[1] |=>
			posCmd_q == $past(posCmd_q) + 32'h1;
	endproperty
	a_step_up: assert property (p_step_up)
		else $error("step with no direction current did not add one");

	property p_step_down;
		@(posedge core_clk) disable iff (reset)
		stepMode && stepFall && filt_q[1] |=>
			posCmd_q == $past(posCmd_q) - 32'h1;
	endproperty
	a_step_down: assert property (p_step_down)
		else $error("step with direction current did not subtract one");

	property p_rise_ignored;
		@(posedge core_clk) disable iff (reset)
		stepRise |=> $stable(stepCount_q);
	endproperty
	a_rise_ignored: assert property (p_rise_ignored)
		else $error("rising step edge changed the count");

	property p_reset_outputs;
		@(posedge core_clk) $past(reset) |-> quadChanAOe && quadChanBOe;
	endproperty
	a_reset_outputs: assert property (p_reset_outputs)
		else $error("channels not outputs after reset");

	property p_quad_inputs;
		@(posedge core_clk) disable iff (reset)
		quadSrc |=> !quadChanAOe && !quadChanBOe;
	endproperty
	a_quad_inputs: assert property (p_quad_inputs)
		else $error("channels still driven with quadrature source");

	property p_quiet;
		@(posedge core_clk) disable iff (reset)
		!hiResFeedback |=> !quadChanAOut && !quadChanBOut;
	endproperty
	a_quiet: assert property (p_quiet)
		else $error("emulated pulses without high-resolution feedback");

	property p_marker_gate;
		@(posedge core_clk) disable iff (reset)
		!serialFeedback |=> !markerPulseOutput;
	endproperty
	a_marker_gate: assert property (p_marker_gate)
		else $error("marker pulse without serial feedback");

	property p_rate;
		@(posedge core_clk) disable iff (reset)
		emuStep |=> !emuStep [*8];
	endproperty
	a_rate: assert property (p_rate)
		else $error("emulated counts closer than the rate limit");

	c_step: cover property (@(posedge core_clk) stepMode && stepFall);
	c_quad_fwd: cover property (@(posedge core_clk)
		quadMode && phDelta == PH_FWD);
	c_marker: cover property (@(posedge core_clk) $rose(markerPulseOutput));
endmodule // servo_step_quadrature_io
`default_nettype wire

/* shared/servo_io_pkg.sv */
`default_nettype none
package servo_io_pkg;
	// ==================================================================
	// clock and timing
	localparam int CLK_PERIOD_NS    = 20;
	localparam int INPUT_FILTER_NS  = 60;   // well under 250 ns step width
	localparam int FILTER_CYCLES    =
		(INPUT_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int QUAD_COUNT_MIN_NS = 200; // 5 MHz count rate ceiling
	localparam int QUAD_GAP_CYCLES  =
		(QUAD_COUNT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// ==================================================================
	// register byte offsets
	localparam logic [11:0] OFS_CTRL       = 12'h000;
	localparam logic [11:0] OFS_GEAR_NUM   = 12'h004;
	localparam logic [11:0] OFS_GEAR_DEN   = 12'h008;
	localparam logic [11:0] OFS_USER_PPR   = 12'h00c;
	localparam logic [11:0] OFS_STATUS     = 12'h010;
	localparam logic [11:0] OFS_POS_CMD    = 12'h014;
	localparam logic [11:0] OFS_STEP_COUNT = 12'h018;
	localparam logic [11:0] OFS_QUAD_COUNT = 12'h01c;
	// ==================================================================
	// control fields
	localparam int CTRL_POS_MODE  = 0;  // operating_mode_select: position
	localparam int CTRL_QUAD_SRC  = 1;  // position_command_source: quad
	localparam int CTRL_A_INPUT   = 2;
	localparam int CTRL_B_INPUT   = 3;
	localparam logic [3:0]  CTRL_RESET     = 4'h0;
	localparam logic [15:0] GEAR_RESET     = 16'h0001;
	localparam logic [3:0]  USER_PPR_RESET = 4'h9; // table entry 500
	localparam int PPR_W = 18;
endpackage
`default_nettype wire

/* verif/step_quad_source.sv */
`default_nettype none
// ==============================================================
// step/direction and quadrature command source
module step_quad_source (
	input  wire logic core_clk,
	output logic      stepPin,
	output logic      dirPin,
	output logic      chanA,
	output logic      chanB
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] phase = 2'b00;

	// no current on either pin until a command starts
	initial begin
		stepPin = 1'b0;
		dirPin = 1'b0;
	end

	// gray phase: A leads B when counting up
	assign chanA = phase[1] ^ phase[0];
	assign chanB = phase[1];

	// one level held 20 cycles: 400 ns pulse, 800 ns period
	task automatic stepLevel(input logic v);
		stepPin <= v;
		repeat (20) @(posedge core_clk);
	endtask

	// direction settles 100 us before the first step
	task automatic sendSteps(input int n, input logic dir);
		dirPin <= dir;
		repeat (5000) @(posedge core_clk);
		repeat (n) begin
			stepLevel(1'b1);
			stepLevel(1'b0);
		end
	endtask

	// 20 cycles per count keeps the line rate at 625 kHz
	task automatic sendQuad(input int n, input logic aLeads);
		repeat (n) begin
			phase <= aLeads ? phase + 2'd1 : phase - 2'd1;
			repeat (20) @(posedge core_clk);
		end
	endtask
endmodule // step_quad_source
`default_nettype wire

/* verif/servo_step_quadrature_io_tb.sv */
`default_nettype none
// ==============================================================
// bench for the command connector logic
module servo_step_quadrature_io_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        core_clk = 1'b0;
	logic        reset = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, posCmd, rd, q0;
	logic        pready, pslverr, lastErr;
	logic        powered = 1'b0;
	logic        faulted = 1'b0;
	logic        enabled = 1'b0;
	logic        hiRes = 1'b0;
	logic        serial = 1'b0;
	logic [19:0] fbPos = 20'h00000;
	logic [3:0]  rotary = 4'h0;
	logic        stepPin, dirPin, chanA, chanB;
	logic        aOut, aOe, bOut, bOe, marker, faultOut, runOut;
	logic        aQ, bQ;
	int          failures = 0;
	int          checked = 0;
	int          edgeCnt = 0;
	int          gap = 100;

	always #10 core_clk = ~core_clk;

	servo_step_quadrature_io u_servo_step_quadrature_io (
		.core_clk(core_clk), .reset(reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .drivePowered(powered),
		.driveFaulted(faulted), .driveEnabled(enabled),
		.hiResFeedback(hiRes), .serialFeedback(serial),
		.feedbackPos(fbPos), .resolutionRotarySwitch(rotary),
		.highSpeedStepInput(stepPin), .directionInput(dirPin),
		.quadChanAIn(chanA), .quadChanBIn(chanB),
		.quadChanAOut(aOut), .quadChanAOe(aOe), .quadChanBOut(bOut),
		.quadChanBOe(bOe), .markerPulseOutput(marker),
		.faultStatusOutput(faultOut), .runStatusOutput(runOut),
		.positionCommand(posCmd));

	step_quad_source u_step_quad_source (.core_clk(core_clk),
		.stepPin(stepPin), .dirPin(dirPin), .chanA(chanA),
		.chanB(chanB));

	// counts emulated counts and flags any spacing under 10 cycles while hiRes and aOe are high
	always @(posedge core_clk) begin
		aQ <= aOut;
		bQ <= bOut;
		gap <= gap + 1;
		if ({aOut, bOut} !== {aQ, bQ}) begin
			edgeCnt <= edgeCnt + 1;
			gap <= 1;
			if (hiRes && aOe && gap < 10) begin
				failures++;
				$display("ERROR count spacing expected 10 seen %0d", gap);
			end
		end
	end

	task automatic chk(input string what, input logic [31:0] exp,
			input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one apb transfer; waits for pready under a bound
	task automatic apb(input logic wr, input logic [11:0] a,
			input logic [31:0] wd);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1 && n < 20) begin
			n++;
			@(posedge core_clk);
		end
		if (n == 20) failures++;
		rd = prdata;
		lastErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	// reset values and an unmapped read
	task automatic resetTest();
		chk("a oe", 1, aOe);
		chk("b oe", 1, bOe);
		apb(1'b0, 12'h008, 0);
		chk("gear den", 1, rd);
		apb(1'b0, 12'h00c, 0);
		chk("user ppr", 9, rd);
		apb(1'b1, 12'h020, 32'h5);
		chk("unmapped err", 1, lastErr);
		apb(1'b0, 12'h020, 0);
		chk("unmapped data", 0, rd);
	endtask

	// every power, fault and enable combination
	task automatic statusTest();
		for (int i = 0; i < 8; i++) begin
			{powered, faulted, enabled} <= i[2:0];
			repeat (3) @(posedge core_clk);
			chk("fault out", i[2] & ~i[1], faultOut);
			chk("run out", i[2] & ~i[1] & i[0], runOut);
		end
	endtask

	// steps count on falling edges only, direction sets sign
	task automatic stepTest();
		logic [31:0] base;
		apb(1'b1, 12'h000, 32'h1);
		base = posCmd;
		u_step_quad_source.sendSteps(3, 1'b0);
		chk("step up", base + 3, posCmd);
		u_step_quad_source.stepLevel(1'b1);
		chk("rising edge", base + 3, posCmd);
		u_step_quad_source.stepLevel(1'b0);
		chk("falling edge", base + 4, posCmd);
		u_step_quad_source.sendSteps(2, 1'b1);
		chk("step down", base + 2, posCmd);
		apb(1'b0, 12'h018, 0);
		chk("step count", 6, rd);
	endtask

	// quadrature decode scaled by gear 3 over 2
	task automatic quadTest();
		apb(1'b1, 12'h004, 32'h3);
		apb(1'b1, 12'h008, 32'h2);
		apb(1'b1, 12'h000, 32'h3);
		@(posedge core_clk);
		chk("a input", 0, aOe);
		chk("b input", 0, bOe);
		apb(1'b0, 12'h01c, 0);
		q0 = rd;
		u_step_quad_source.sendQuad(8, 1'b1);
		apb(1'b0, 12'h01c, 0);
		chk("a leads", q0 + 8, rd);
		chk("scaled up", $signed(rd) * 3 / 2, posCmd);
		u_step_quad_source.sendQuad(12, 1'b0);
		apb(1'b0, 12'h01c, 0);
		chk("b leads", q0 - 4, rd);
		chk("scaled down", $signed(rd) * 3 / 2, posCmd);
		apb(1'b1, 12'h000, 32'h4);
		@(posedge core_clk);
		chk("a only input", 2'b01, {aOe, bOe});
		apb(1'b1, 12'h000, 32'h0);
	endtask

	// 1/64 turn gives ppr/16 counts for switch positions 0 to 9
	task automatic emuTest();
		int ppr[10] = '{500, 512, 1000, 1024, 2000, 2048, 4096,
			5000, 8192, 10000};
		int base, exp, n;
		serial <= 1'b1;
		fbPos <= 20'h04000;
		for (int i = 0; i < 10; i++) begin
			hiRes <= 1'b0;
			rotary <= i[3:0];
			// long enough that the drop to zero is not a short gap
			repeat (12) @(posedge core_clk);
			chk("quiet a", 0, aOut);
			base = edgeCnt;
			exp = ppr[i] / 16;
			hiRes <= 1'b1;
			repeat (4) @(posedge core_clk);
			chk("marker at zero", 1, marker);
			n = 0;
			while (edgeCnt - base < exp && n < 15 * exp + 100) begin
				n++;
				@(posedge core_clk);
			end
			repeat (40) @(posedge core_clk);
			chk("emulated counts", exp, edgeCnt - base);
			chk("marker past one", 0, marker);
		end
		hiRes <= 1'b0;
		serial <= 1'b0;
		repeat (12) @(posedge core_clk);
		hiRes <= 1'b1;
		repeat (4) @(posedge core_clk);
		chk("marker no serial", 0, marker);
		hiRes <= 1'b0;
		// let the counter's drop to zero pass before counting
		repeat (4) @(posedge core_clk);
		base = edgeCnt;
		fbPos <= 20'h80000;
		repeat (60) @(posedge core_clk);
		chk("six-step quiet", 0, edgeCnt - base);
		chk("six-step low", 0, {aOut, bOut});
	endtask

	// watchdog well past the expected run length
	initial begin
		repeat (60000) @(posedge core_clk);
		failures++;
		give_verdict();
	end

	// main sequence
	initial begin
		repeat (4) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		resetTest();
		statusTest();
		stepTest();
		quadTest();
		emuTest();
		give_verdict();
	end
endmodule // servo_step_quadrature_io_tb
`default_nettype wire
